// ==== hdl/ihl_ack_hold.sv ====
/*
 * Interrupt acknowledge hold logic: latches request flags, picks the
 * winning unmasked request and acknowledges it at an instruction boundary,
 * except at the end of a hold-class instruction or a software break.
 * Assumes the sequencer pulses instr_done once per completed instruction
 * with its descriptor, and that request pulses come from same-clock logic.
 */
`default_nettype none
module ihl_ack_hold (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // instruction sequencer
   input wire logic instr_done,
   input wire ihl_pkg::ihl_instr_t instr,
   input wire logic global_interrupt_enable_flag,
   // request sources and flag registers
   input wire logic [ihl_pkg::IHL_NSRC-1:0] irq_pulse,
   input wire logic [ihl_pkg::IHL_NSRC-1:0] mask_flags,
   input wire logic [ihl_pkg::IHL_NSRC-1:0] prio_flags,
   // acknowledge
   output logic [ihl_pkg::IHL_NSRC-1:0] req_flags,
   output logic hold_active,
   output logic ack_valid,
   output logic [ihl_pkg::IHL_SRCW-1:0] ack_src,
   output logic enable_clear
);
   import ihl_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ihl_state_t st_r;
   ihl_state_t st_nxt;
   logic hold_now;
   logic is_break;
   logic [IHL_NSRC-1:0] live;
   logic [IHL_NSRC-1:0] hi_live;
   logic [IHL_SRCW-1:0] pick;
   logic any_live;

   function automatic logic [IHL_SRCW-1:0] lowest(input logic [IHL_NSRC-1:0] v);
      lowest = IHL_SRC_RST;
      for (int i = IHL_NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            lowest = IHL_SRCW'(i);
         end
      end
   endfunction : lowest

   // ----------------------------------------------------------------
   // selection
   // ----------------------------------------------------------------
   always_comb begin
      hold_now = ihl_is_hold(instr);
      is_break = (instr.op == IHL_OP_SOFTWARE_BREAK);
      live = st_r.flags & ~mask_flags;
      hi_live = live & ~prio_flags;
      any_live = |live;
      pick = (|hi_live) ? lowest(hi_live) : lowest(live);
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.enable_clear = 1'b0;
      if (instr_done) begin
         st_nxt.hold = hold_now;
         if (is_break) begin
            st_nxt.enable_clear = 1'b1;
         end else if (!hold_now && global_interrupt_enable_flag && any_live) begin
            st_nxt.ack = 1'b1;
            st_nxt.src = pick;
            st_nxt.enable_clear = 1'b1;
            st_nxt.flags[pick] = 1'b0;
         end
      end
      st_nxt.flags = st_nxt.flags | irq_pulse;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '{hold: 1'b0, flags: IHL_FLAGS_RST, ack: 1'b0, src: IHL_SRC_RST, enable_clear: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign req_flags = st_r.flags;
   assign hold_active = st_r.hold;
   assign ack_valid = st_r.ack;
   assign ack_src = st_r.src;
   assign enable_clear = st_r.enable_clear;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence s_hold_end;
      instr_done && ihl_is_hold(instr);
   endsequence

   sequence s_plain_end_ready;
      instr_done && !ihl_is_hold(instr) && instr.op != IHL_OP_SOFTWARE_BREAK
         && global_interrupt_enable_flag && |(st_r.flags & ~mask_flags);
   endsequence

   sequence s_flag_access;
      instr_done && instr.sfr_operand && instr.op != IHL_OP_OTHER && instr.op != IHL_OP_SOFTWARE_BREAK;
   endsequence

   a_hold_no_ack: assert property (s_hold_end |=> !ack_valid && hold_active)
      else $error("acknowledge at end of hold-class instruction");
   a_status_is_hold: assert property (instr_done && instr.status_operand && instr.op != IHL_OP_OTHER
         && instr.op != IHL_OP_SOFTWARE_BREAK |=> !ack_valid)
      else $error("status word instruction did not defer");
   a_flagreg_hold: assert property (instr_done && instr.sfr_operand && instr.op == IHL_OP_MOV
         && instr.sfr_addr == IHL_ADR_MSK0_LO |=> hold_active)
      else $error("flag register access did not defer");
   a_break_not_hold: assert property (instr_done && instr.op == IHL_OP_SOFTWARE_BREAK
         |=> !hold_active)
      else $error("software break treated as hold-class");
   a_break_en_clr: assert property (instr_done && instr.op == IHL_OP_SOFTWARE_BREAK
         |=> enable_clear && !ack_valid)
      else $error("break entry did not clear enable or was acknowledged");
   a_hold_then_ack: assert property (hold_active ##0 s_plain_end_ready
         |=> ack_valid && enable_clear)
      else $error("no acknowledge after deferral window");
   a_irq_sets_flag: assert property (|irq_pulse |=> (req_flags & $past(irq_pulse)) == $past(irq_pulse))
      else $error("request pulse not latched");
   a_flag_kept: assert property ((req_flags != '0) && !ack_valid ##0 !$rose(ack_valid)
         |=> ((req_flags & $past(req_flags)) == $past(req_flags)) || ack_valid)
      else $error("pending flag lost without acknowledge");
   a_ack_src_ok: assert property (ack_valid
         |-> (($past(req_flags) & ~$past(mask_flags)) & (IHL_NSRC'(1) << ack_src)) != '0)
      else $error("acknowledged source was not pending and unmasked");

   // ----------------------------------------------------------------
   // checks: hold-class decode
   // ----------------------------------------------------------------
   a_iret_hold: assert property (instr_done && instr.op == IHL_OP_INTERRUPT_RETURN
         |=> hold_active && !ack_valid)
      else $error("interrupt return did not defer");

   a_bret_hold: assert property (instr_done && instr.op == IHL_OP_BREAK_RETURN
         |=> hold_active && !ack_valid)
      else $error("break return did not defer");

   a_unmask_hold: assert property (instr_done && instr.op == IHL_OP_GLOBAL_INT_UNMASK
         |=> hold_active && !ack_valid)
      else $error("enable op did not defer");

   a_mask_hold: assert property (instr_done && instr.op == IHL_OP_GLOBAL_INT_MASK
         |=> hold_active && !ack_valid)
      else $error("disable op did not defer");

   a_status_hold: assert property (instr_done && instr.status_operand && instr.op != IHL_OP_OTHER
         && instr.op != IHL_OP_SOFTWARE_BREAK |=> hold_active)
      else $error("status word access not hold-class");

   a_req_byte_hold: assert property (s_flag_access ##0 (instr.sfr_addr == IHL_ADR_REQ0_LO
         || instr.sfr_addr == IHL_ADR_REQ0_HI || instr.sfr_addr == IHL_ADR_REQ1_LO
         || instr.sfr_addr == IHL_ADR_REQ1_HI) |=> hold_active)
      else $error("request flag byte access not hold-class");

   a_msk_byte_hold: assert property (s_flag_access ##0 (instr.sfr_addr == IHL_ADR_MSK0_LO
         || instr.sfr_addr == IHL_ADR_MSK0_HI || instr.sfr_addr == IHL_ADR_MSK1_LO
         || instr.sfr_addr == IHL_ADR_MSK1_HI) |=> hold_active)
      else $error("mask flag byte access not hold-class");

   a_pri_byte_hold: assert property (s_flag_access ##0 (instr.sfr_addr == IHL_ADR_PRI0_LO
         || instr.sfr_addr == IHL_ADR_PRI0_HI || instr.sfr_addr == IHL_ADR_PRI1_LO
         || instr.sfr_addr == IHL_ADR_PRI1_HI) |=> hold_active)
      else $error("priority flag byte access not hold-class");

   a_other_no_hold: assert property (instr_done && instr.op == IHL_OP_OTHER |=> !hold_active)
      else $error("ordinary instruction treated as hold-class");

   a_hold_steady: assert property (!instr_done |=> hold_active == $past(hold_active))
      else $error("hold state changed between boundaries");

   // ----------------------------------------------------------------
   // checks: acknowledge
   // ----------------------------------------------------------------
   a_ack_at_edge: assert property (!instr_done |=> !ack_valid)
      else $error("acknowledge away from an instruction boundary");

   a_ack_needs_en: assert property (ack_valid |-> $past(global_interrupt_enable_flag))
      else $error("acknowledge while interrupts disabled");

   a_ack_with_clr: assert property (ack_valid |-> enable_clear)
      else $error("acknowledge without enable clear");

   a_clr_at_edge: assert property (!instr_done |=> !enable_clear)
      else $error("enable clear away from an instruction boundary");

   a_ack_flag_clr: assert property (ack_valid
         |-> ((req_flags & ~$past(irq_pulse)) & (IHL_NSRC'(1) << ack_src)) == '0)
      else $error("acknowledged flag not cleared");

   a_ack_prio_first: assert property (ack_valid
         && ($past(req_flags & ~mask_flags & ~prio_flags) != '0)
         |-> ((~$past(prio_flags)) & (IHL_NSRC'(1) << ack_src)) != '0)
      else $error("low priority request chosen over high priority");

   a_no_live_no_ack: assert property (instr_done && ((req_flags & ~mask_flags) == '0) |=> !ack_valid)
      else $error("acknowledge with no live request");

   // ----------------------------------------------------------------
   // checks: request flags
   // ----------------------------------------------------------------
   a_flags_accumulate: assert property (!instr_done
         |=> req_flags == ($past(req_flags) | $past(irq_pulse)))
      else $error("request flags changed between boundaries");

   a_brk_keeps_flags: assert property (instr_done && instr.op == IHL_OP_SOFTWARE_BREAK
         |=> (req_flags & $past(req_flags)) == $past(req_flags))
      else $error("request lost at software break");

   a_hold_keeps_flags: assert property (s_hold_end
         |=> (req_flags & $past(req_flags)) == $past(req_flags))
      else $error("request lost at end of hold-class instruction");
endmodule : ihl_ack_hold
`default_nettype wire

// ==== hdl/ihl_pkg.sv ====
/*
 * Package for the interrupt acknowledge hold logic: instruction descriptor,
 * request-group addresses, field widths and the hold-class decode function.
 * Assumes the instruction sequencer presents one descriptor per completed
 * instruction, on the same clock as this block.
 */
// Notes on behaviour
// - hold-class instruction defers acknowledge past next one
// - status word accesses, returns, enable ops hold
// - request, mask, priority flag byte accesses are hold-class
// - software break is never hold-class
// - break entry clears enable; no maskable acknowledge
// - after deferral, save status, PC, then vector
// - priority never affects request flag setting
`default_nettype none
package ihl_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned IHL_NSRC = 32;
   localparam int unsigned IHL_SRCW = 5;
   localparam int unsigned IHL_ADRW = 8;
   localparam int unsigned IHL_NFLAGREG = 12;

   // ----------------------------------------------------------------
   // special register addresses of the flag bytes
   // ----------------------------------------------------------------
   localparam logic [IHL_ADRW-1:0] IHL_ADR_REQ0_LO = 8'hE0;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_REQ0_HI = 8'hE1;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_REQ1_LO = 8'hE2;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_REQ1_HI = 8'hE3;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_MSK0_LO = 8'hE4;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_MSK0_HI = 8'hE5;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_MSK1_LO = 8'hE6;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_MSK1_HI = 8'hE7;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_PRI0_LO = 8'hE8;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_PRI0_HI = 8'hE9;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_PRI1_LO = 8'hEA;
   localparam logic [IHL_ADRW-1:0] IHL_ADR_PRI1_HI = 8'hEB;
   localparam logic [IHL_NFLAGREG*IHL_ADRW-1:0] IHL_FLAG_ADRS = {
      IHL_ADR_REQ0_LO, IHL_ADR_REQ0_HI, IHL_ADR_REQ1_LO, IHL_ADR_REQ1_HI,
      IHL_ADR_MSK0_LO, IHL_ADR_MSK0_HI, IHL_ADR_MSK1_LO, IHL_ADR_MSK1_HI,
      IHL_ADR_PRI0_LO, IHL_ADR_PRI0_HI, IHL_ADR_PRI1_LO, IHL_ADR_PRI1_HI};

   localparam logic [IHL_NSRC-1:0] IHL_FLAGS_RST = 32'h0000_0000;
   localparam logic [IHL_SRCW-1:0] IHL_SRC_RST = 5'h00;

   // ----------------------------------------------------------------
   // instruction kinds and descriptor
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      IHL_OP_OTHER, IHL_OP_MOV, IHL_OP_BITMOV, IHL_OP_BITLOGIC, IHL_OP_SET1,
      IHL_OP_CLR1, IHL_OP_PUSH, IHL_OP_POP, IHL_OP_BITBRANCH,
      IHL_OP_INTERRUPT_RETURN, IHL_OP_BREAK_RETURN, IHL_OP_GLOBAL_INT_UNMASK,
      IHL_OP_GLOBAL_INT_MASK, IHL_OP_SOFTWARE_BREAK
   } ihl_op_t;

   typedef struct packed {
      ihl_op_t op;
      logic status_operand;
      logic sfr_operand;
      logic [IHL_ADRW-1:0] sfr_addr;
   } ihl_instr_t;

   // ----------------------------------------------------------------
   // hold-class decode
   // ----------------------------------------------------------------
   function automatic logic ihl_is_hold(input ihl_instr_t ins);
      logic flag_reg;
      flag_reg = 1'b0;
      for (int i = 0; i < IHL_NFLAGREG; i++) begin
         if (ins.sfr_addr == IHL_FLAG_ADRS[i*IHL_ADRW +: IHL_ADRW]) begin
            flag_reg = 1'b1;
         end
      end
      unique case (ins.op)
         IHL_OP_SOFTWARE_BREAK: ihl_is_hold = 1'b0;
         IHL_OP_INTERRUPT_RETURN, IHL_OP_BREAK_RETURN,
         IHL_OP_GLOBAL_INT_UNMASK, IHL_OP_GLOBAL_INT_MASK: ihl_is_hold = 1'b1;
         IHL_OP_OTHER: ihl_is_hold = 1'b0;
         default: ihl_is_hold = ins.status_operand
                              | (ins.sfr_operand & flag_reg);
      endcase
   endfunction : ihl_is_hold

   typedef struct packed {
      logic hold;
      logic [IHL_NSRC-1:0] flags;
      logic ack;
      logic [IHL_SRCW-1:0] src;
      logic enable_clear;
   } ihl_state_t;
endpackage : ihl_pkg
`default_nettype wire

// ==== test/ihl_seq_model.sv ====
/* sequencer model: completes one instruction per step call, keeps
   the global enable; assumes the bench calls step between edges */
`default_nettype none
module ihl_seq_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // to the block
   output logic instr_done,
   output ihl_pkg::ihl_instr_t instr,
   output logic global_interrupt_enable_flag,
   // from the block
   input wire logic enable_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   import ihl_pkg::*;
   initial begin
      instr_done = 1'b0;
      instr = '0;
   end
   // entry clears enable, unmask op sets it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) global_interrupt_enable_flag <= 1'b1;
      else if (enable_clear) global_interrupt_enable_flag <= 1'b0;
      else if (instr_done && instr.op == IHL_OP_GLOBAL_INT_UNMASK) global_interrupt_enable_flag <= 1'b1;
      else if (instr_done && instr.op == IHL_OP_GLOBAL_INT_MASK) global_interrupt_enable_flag <= 1'b0;
   end
   task automatic step(input ihl_instr_t i);
      @(negedge clk_sys);
      instr_done = 1'b1;
      instr = i;
      @(negedge clk_sys);
      instr_done = 1'b0;
      instr = ~i;
   endtask : step
endmodule : ihl_seq_model
`default_nettype wire

// ==== test/tb_top.sv ====
/* bench for ihl_ack_hold: scenario tasks raise requests and judge the
   acknowledge; assumes ihl_seq_model as the instruction sequencer */
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import ihl_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [IHL_NSRC-1:0] irq_pulse = '0;
   logic [IHL_NSRC-1:0] mask_flags = '0;
   logic [IHL_NSRC-1:0] prio_flags = '1;
   logic [IHL_NSRC-1:0] req_flags;
   logic hold_active, ack_valid, enable_clear, instr_done, gie;
   logic [IHL_SRCW-1:0] ack_src;
   ihl_instr_t instr;
   int failures = 0;
   int check_count = 0;
   always #4 clk_sys = ~clk_sys;
   ihl_seq_model seq_u (.clk_sys(clk_sys), .arst_n(arst_n), .instr_done(instr_done), .instr(instr),
      .global_interrupt_enable_flag(gie), .enable_clear(enable_clear));
   ihl_ack_hold dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .instr_done(instr_done), .instr(instr),
      .global_interrupt_enable_flag(gie), .irq_pulse(irq_pulse), .mask_flags(mask_flags),
      .prio_flags(prio_flags), .req_flags(req_flags), .hold_active(hold_active),
      .ack_valid(ack_valid), .ack_src(ack_src), .enable_clear(enable_clear));
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic raise(input logic [IHL_NSRC-1:0] bits);
      @(negedge clk_sys);
      irq_pulse = bits;
      @(negedge clk_sys);
      irq_pulse = '0;
   endtask : raise
   function automatic ihl_instr_t mk(input ihl_op_t op, input logic p, input logic s, input logic [7:0] a);
      mk = '{op: op, status_operand: p, sfr_operand: s, sfr_addr: a};
   endfunction : mk
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_hold(input ihl_instr_t i, input logic exp_ack);
      seq_u.step(mk(IHL_OP_GLOBAL_INT_UNMASK, 1'b0, 1'b0, 8'h00));
      raise(32'h0000_0008);
      seq_u.step(i);
      chk(ack_valid, 1'b0);
      chk(hold_active, 1'b1);
      chk(req_flags[3], 1'b1);
      seq_u.step(mk(IHL_OP_OTHER, 1'b0, 1'b0, 8'h00));
      chk(ack_valid, exp_ack);
      chk(ack_src, 5'h03);
      chk(req_flags[3], !exp_ack);
      chk(hold_active, 1'b0);
   endtask : t_hold
   task automatic t_prio();
      prio_flags = 32'hFFFF_FDFF;
      seq_u.step(mk(IHL_OP_GLOBAL_INT_UNMASK, 1'b0, 1'b0, 8'h00));
      raise(32'h0000_0204);
      chk(req_flags, 32'h0000_0204);
      seq_u.step(mk(IHL_OP_MOV, 1'b0, 1'b1, 8'hDF));
      chk(ack_valid, 1'b1);
      chk(ack_src, 5'h09);
      seq_u.step(mk(IHL_OP_GLOBAL_INT_UNMASK, 1'b0, 1'b0, 8'h00));
      seq_u.step(mk(IHL_OP_OTHER, 1'b0, 1'b0, 8'h00));
      chk(ack_valid, 1'b1);
      chk(ack_src, 5'h02);
      prio_flags = '1;
   endtask : t_prio
   task automatic t_brk();
      seq_u.step(mk(IHL_OP_GLOBAL_INT_UNMASK, 1'b0, 1'b0, 8'h00));
      raise(32'h0000_0040);
      seq_u.step(mk(IHL_OP_SOFTWARE_BREAK, 1'b1, 1'b0, 8'h00));
      chk({enable_clear, ack_valid, hold_active}, 3'h4);
      seq_u.step(mk(IHL_OP_OTHER, 1'b0, 1'b0, 8'h00));
      chk({ack_valid, req_flags[6]}, 2'h1);
      seq_u.step(mk(IHL_OP_GLOBAL_INT_UNMASK, 1'b0, 1'b0, 8'h00));
      chk({ack_valid, hold_active}, 2'h1);
      seq_u.step(mk(IHL_OP_OTHER, 1'b0, 1'b0, 8'h00));
      chk({ack_valid, enable_clear, ack_src}, 7'h66);
   endtask : t_brk
   initial begin
      #100000;
      failures++;
      conclude();
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      arst_n = 1'b1;
      chk({ack_valid, hold_active}, 2'h0);
      chk(req_flags, 32'h0000_0000);
      for (int k = 1; k < 13; k++) t_hold(mk(ihl_op_t'(k), k < 9, 1'b0, 8'h00), ihl_op_t'(k) != IHL_OP_GLOBAL_INT_MASK);
      for (int a = 0; a < 12; a++) t_hold(mk(IHL_OP_MOV, 1'b0, 1'b1, 8'(8'hE0 + a)), 1'b1);
      t_prio();
      t_brk();
      conclude();
   end
endmodule : tb_top
`default_nettype wire
